/* File: inc/aidt_pkg.sv */
// constants and carriers for the arithmetic decode and timing block
// assumes a single core clock; opcode bytes arrive from fetch already aligned
package aidt_pkg;
  // opcode patterns and masks
  localparam logic [7:0] OP_SBB_PAIR_MASK = 8'hfc;
  localparam logic [7:0] OP_SBB_PAIR = 8'h18;
  localparam logic [7:0] OP_GRP1_MASK = 8'hfc;
  localparam logic [7:0] OP_GRP1 = 8'h80;
  localparam logic [7:0] OP_SBB_ACC_MASK = 8'hfe;
  localparam logic [7:0] OP_SBB_ACC = 8'h1c;
  localparam logic [7:0] OP_GRP3_MASK = 8'hfe;
  localparam logic [7:0] OP_GRP3 = 8'hf6;
  localparam logic [7:0] OP_SIGNED_MULTIPLY_IMM_MASK = 8'hfd;
  localparam logic [7:0] OP_SIGNED_MULTIPLY_IMM = 8'h69;
  localparam logic [7:0] OP_UADD_CORR = 8'h37;
  localparam logic [7:0] OP_PADD_CORR = 8'h27;
  localparam logic [7:0] OP_USUB_CORR = 8'h3f;
  localparam logic [7:0] OP_PSUB_CORR = 8'h2f;
  // reg-field extensions
  localparam logic [2:0] EXT_SBB = 3'h3;
  localparam logic [2:0] EXT_NEG = 3'h3;
  localparam logic [2:0] EXT_MUL = 3'h4;
  localparam logic [2:0] EXT_SIGNED_MULTIPLY = 3'h5;
  localparam logic [1:0] MOD_REG = 2'h3;
  // cycle counts (worst case of each range)
  localparam logic [5:0] CYC_SBB_PAIR_R = 6'h03;
  localparam logic [5:0] CYC_SBB_PAIR_M = 6'h0a;
  localparam logic [5:0] CYC_SBB_IMM_R = 6'h04;
  localparam logic [5:0] CYC_SBB_IMM_M = 6'h10;
  localparam logic [5:0] CYC_SBB_ACC_B = 6'h03;
  localparam logic [5:0] CYC_SBB_ACC_W = 6'h04;
  localparam logic [5:0] CYC_NEG_R = 6'h03;
  localparam logic [5:0] CYC_NEG_M = 6'h0a;
  localparam logic [5:0] CYC_UADD = 6'h08;
  localparam logic [5:0] CYC_PADD = 6'h04;
  localparam logic [5:0] CYC_USUB = 6'h07;
  localparam logic [5:0] CYC_PSUB = 6'h04;
  localparam logic [5:0] CYC_MUL_RB = 6'h1c;
  localparam logic [5:0] CYC_MUL_RW = 6'h25;
  localparam logic [5:0] CYC_MUL_MB = 6'h22;
  localparam logic [5:0] CYC_MUL_MW = 6'h2b;
  localparam logic [5:0] CYC_SIGNED_MULTIPLY_RB = 6'h1c;
  localparam logic [5:0] CYC_SIGNED_MULTIPLY_RW = 6'h25;
  localparam logic [5:0] CYC_SIGNED_MULTIPLY_MB16 = 6'h22;
  localparam logic [5:0] CYC_SIGNED_MULTIPLY_MB8 = 6'h25;
  localparam logic [5:0] CYC_SIGNED_MULTIPLY_MW = 6'h2b;
  localparam logic [5:0] CYC_IMULI_R = 6'h19;
  localparam logic [5:0] CYC_IMULI_M = 6'h20;

  typedef enum logic [3:0] {
    AIDT_OP_NONE,
    AIDT_OP_BORROW_SUBTRACT,
    AIDT_OP_NEGATE_OPERAND,
    AIDT_OP_UNPACKED_ADD_CORRECT,
    AIDT_OP_PACKED_ADD_CORRECT,
    AIDT_OP_UNPACKED_SUB_CORRECT,
    AIDT_OP_PACKED_SUB_CORRECT,
    AIDT_OP_UNSIGNED_MULTIPLY,
    AIDT_OP_SIGNED_MULTIPLY,
    AIDT_OP_SIGNED_MULTIPLY_IMM
  } aidt_op_e;

  typedef enum logic [1:0] {
    AIDT_FORM_PAIR,
    AIDT_FORM_IMM_RM,
    AIDT_FORM_IMM_ACC,
    AIDT_FORM_SINGLE
  } aidt_form_e;

  // fetched instruction head
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
  } aidt_insn_s;

  // decode result
  typedef struct packed {
    aidt_op_e op;
    aidt_form_e form;
    logic word;
    logic mem;
    logic imm_word;
    logic [5:0] cycles;
  } aidt_dec_s;
endpackage

/* File: logic/aidt_decode.sv */
// combinational opcode decoder with cycle lookup
// assumes the modrm byte is valid whenever the opcode needs one
`timescale 1ns/1ps
module aidt_decode (
  input wire aidt_pkg::aidt_insn_s insn_in,
  input wire logic narrow_bus_in,
  output aidt_pkg::aidt_dec_s dec_out
);
  import aidt_pkg::*;

  function automatic logic [5:0] pick(input logic m, input logic [5:0] r, input logic [5:0] mm);
    pick = m ? mm : r;
  endfunction

  wire [7:0] op = insn_in.opcode;
  wire [2:0] ext = insn_in.modrm[5:3];
  wire mem = (insn_in.modrm[7:6] != MOD_REG);
  wire w = op[0];
  wire hit_pair = ((op & OP_SBB_PAIR_MASK) == OP_SBB_PAIR);
  wire hit_imm = ((op & OP_GRP1_MASK) == OP_GRP1) && (ext == EXT_SBB);
  wire hit_acc = ((op & OP_SBB_ACC_MASK) == OP_SBB_ACC);
  wire grp3 = ((op & OP_GRP3_MASK) == OP_GRP3);
  wire hit_neg = grp3 && (ext == EXT_NEG);
  wire hit_mul = grp3 && (ext == EXT_MUL);
  wire hit_signed_multiply = grp3 && (ext == EXT_SIGNED_MULTIPLY);
  wire hit_imuli = ((op & OP_SIGNED_MULTIPLY_IMM_MASK) == OP_SIGNED_MULTIPLY_IMM);
  wire [5:0] signed_multiply_mb = narrow_bus_in ? CYC_SIGNED_MULTIPLY_MB8 : CYC_SIGNED_MULTIPLY_MB16;

  always_comb begin
    dec_out = '0;
    dec_out.op = AIDT_OP_NONE;
    dec_out.form = AIDT_FORM_SINGLE;
    dec_out.word = w;
    dec_out.mem = mem;
    if (hit_pair) begin // RQ1
      dec_out.op = AIDT_OP_BORROW_SUBTRACT;
      dec_out.form = AIDT_FORM_PAIR;
      dec_out.cycles = pick(mem, CYC_SBB_PAIR_R, CYC_SBB_PAIR_M); // RQ2
    end else if (hit_imm) begin // RQ1
      dec_out.op = AIDT_OP_BORROW_SUBTRACT;
      dec_out.form = AIDT_FORM_IMM_RM;
      dec_out.imm_word = (op[1:0] == 2'h1);
      dec_out.cycles = pick(mem, CYC_SBB_IMM_R, CYC_SBB_IMM_M); // RQ2
    end else if (hit_acc) begin // RQ1
      dec_out.op = AIDT_OP_BORROW_SUBTRACT;
      dec_out.form = AIDT_FORM_IMM_ACC;
      dec_out.mem = 1'b0;
      dec_out.imm_word = w;
      dec_out.cycles = w ? CYC_SBB_ACC_W : CYC_SBB_ACC_B; // RQ2
    end else if (hit_neg) begin
      dec_out.op = AIDT_OP_NEGATE_OPERAND;
      dec_out.cycles = pick(mem, CYC_NEG_R, CYC_NEG_M); // RQ3
    end else if (hit_mul) begin
      dec_out.op = AIDT_OP_UNSIGNED_MULTIPLY;
      dec_out.cycles = w ? pick(mem, CYC_MUL_RW, CYC_MUL_MW)
                         : pick(mem, CYC_MUL_RB, CYC_MUL_MB); // RQ8
    end else if (hit_signed_multiply) begin
      dec_out.op = AIDT_OP_SIGNED_MULTIPLY;
      dec_out.cycles = w ? pick(mem, CYC_SIGNED_MULTIPLY_RW, CYC_SIGNED_MULTIPLY_MW)
                         : pick(mem, CYC_SIGNED_MULTIPLY_RB, signed_multiply_mb); // RQ9
    end else if (hit_imuli) begin
      dec_out.op = AIDT_OP_SIGNED_MULTIPLY_IMM;
      dec_out.form = AIDT_FORM_IMM_RM;
      dec_out.word = 1'b1;
      dec_out.imm_word = ~op[1]; // RQ10
      dec_out.cycles = pick(mem, CYC_IMULI_R, CYC_IMULI_M); // RQ10
    end else begin
      dec_out.mem = 1'b0;
      case (op)
        OP_UADD_CORR: begin
          dec_out.op = AIDT_OP_UNPACKED_ADD_CORRECT;
          dec_out.cycles = CYC_UADD; // RQ4
        end
        OP_PADD_CORR: begin
          dec_out.op = AIDT_OP_PACKED_ADD_CORRECT;
          dec_out.cycles = CYC_PADD; // RQ5
        end
        OP_USUB_CORR: begin
          dec_out.op = AIDT_OP_UNPACKED_SUB_CORRECT;
          dec_out.cycles = CYC_USUB; // RQ6
        end
        OP_PSUB_CORR: begin
          dec_out.op = AIDT_OP_PACKED_SUB_CORRECT;
          dec_out.cycles = CYC_PSUB; // RQ7
        end
        default: begin
          dec_out.cycles = 6'h00;
        end
      endcase
    end
  end
endmodule

/* File: logic/aidt_core.sv */
// What this block does
// [RQ1] borrow-subtract decoded in pair, immediate, accumulator forms
// [RQ2] borrow-subtract cycles 3/10, 4/16, 3/4
// [RQ3] negate: group opcode ext 011, 3/10 cycles
// [RQ4] unpacked add correction, 8 cycles
// [RQ5] packed add correction, 4 cycles
// [RQ6] unpacked subtract correction, 7 cycles
// [RQ7] packed subtract correction, 4 cycles
// [RQ8] unsigned multiply ext 100, byte/word reg/mem cycles
// [RQ9] signed multiply ext 101, bus-width dependent memory byte
// [RQ10] immediate signed multiply, word immediate when s=0
// [RQ11] hold next issue until count done, one-cycle writeback
//
// file: arithmetic decode and execution timing top
// assumes fetch holds insn_in stable while valid_in is high and ready_out low
`timescale 1ns/1ps
module aidt_core (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic valid_in,
  input wire aidt_pkg::aidt_insn_s insn_in,
  input wire logic narrow_bus_in,
  output logic ready_out,
  output logic busy_out,
  output aidt_pkg::aidt_op_e op_out,
  output aidt_pkg::aidt_form_e form_out,
  output logic word_out,
  output logic mem_out,
  output logic imm_word_out,
  output logic writeback_out,
  output logic unknown_out
);
  import aidt_pkg::*;

  typedef enum logic [1:0] {AIDT_IDLE, AIDT_RUN, AIDT_WB} aidt_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  aidt_dec_s dec;
  aidt_decode u_dec (
    .insn_in(insn_in),
    .narrow_bus_in(narrow_bus_in),
    .dec_out(dec)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  aidt_state_e state;
  aidt_state_e next_state;
  logic [5:0] count;
  logic [5:0] next_count;
  wire known = (dec.op != AIDT_OP_NONE);
  wire take = valid_in && ready_out;
  wire start = take && known;
  wire last = (count == 6'h01);

  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      AIDT_IDLE: begin
        if (start) begin
          next_count = dec.cycles - 6'h01;
          next_state = (dec.cycles == 6'h01) ? AIDT_WB : AIDT_RUN;
        end
      end
      AIDT_RUN: begin
        next_count = count - 6'h01;
        if (last) begin // RQ11
          next_state = AIDT_WB;
        end
      end
      AIDT_WB: begin
        next_state = AIDT_IDLE;
      end
      default: begin
        next_state = AIDT_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      state <= AIDT_IDLE;
      count <= 6'h00;
    end else if (ce_in) begin
      state <= next_state;
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      ready_out <= 1'b1;
      busy_out <= 1'b0;
      writeback_out <= 1'b0;
      unknown_out <= 1'b0;
      op_out <= AIDT_OP_NONE;
      form_out <= AIDT_FORM_SINGLE;
      word_out <= 1'b0;
      mem_out <= 1'b0;
      imm_word_out <= 1'b0;
    end else if (ce_in) begin
      ready_out <= (next_state == AIDT_IDLE); // RQ11
      busy_out <= (next_state != AIDT_IDLE);
      writeback_out <= (next_state == AIDT_WB); // RQ11
      unknown_out <= take && !known;
      if (start) begin
        op_out <= dec.op;
        form_out <= dec.form;
        word_out <= dec.word;
        mem_out <= dec.mem;
        imm_word_out <= dec.imm_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [5:0] run_len;
  logic [5:0] exp_len;
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      run_len <= 6'h00;
      exp_len <= 6'h00;
    end else if (ce_in) begin
      if (start) begin
        run_len <= 6'h01;
        exp_len <= dec.cycles;
      end else if (busy_out && !writeback_out) begin
        run_len <= run_len + 6'h01;
      end
    end
  end

  a_wb_after_count: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    (ce_in && writeback_out) |-> (run_len == exp_len))
    else $error("writeback before full cycle count");

  a_wb_one_cycle: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    (ce_in && writeback_out) |=> (ce_in -> !writeback_out))
    else $error("writeback longer than one cycle");

  a_no_issue_busy: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    busy_out |-> !ready_out)
    else $error("ready while busy");

  a_sbb_pair_time: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ2
    (dec.op == AIDT_OP_BORROW_SUBTRACT && dec.form == AIDT_FORM_PAIR)
      |-> (dec.cycles == (dec.mem ? 6'h0a : 6'h03)))
    else $error("borrow-subtract pair timing wrong");

  a_sbb_acc_dec: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ1
    (insn_in.opcode[7:1] == 7'h0e) |-> (dec.form == AIDT_FORM_IMM_ACC
      && dec.cycles == (insn_in.opcode[0] ? 6'h04 : 6'h03)))
    else $error("accumulator borrow-subtract misdecoded");

  a_neg_time: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ3
    (insn_in.opcode[7:1] == 7'h7b && insn_in.modrm[5:3] == 3'h3)
      |-> (dec.op == AIDT_OP_NEGATE_OPERAND && dec.cycles == (dec.mem ? 6'h0a : 6'h03)))
    else $error("negate misdecoded");

  a_adjust_time: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ4
    (insn_in.opcode == 8'h37) |-> (dec.cycles == 6'h08))
    else $error("unpacked add correction timing wrong");

  a_mul_word_mem: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ8
    (dec.op == AIDT_OP_UNSIGNED_MULTIPLY && dec.word && dec.mem) |-> (dec.cycles == 6'h2b))
    else $error("unsigned multiply memory word timing wrong");

  a_signed_multiply_narrow: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ9
    (dec.op == AIDT_OP_SIGNED_MULTIPLY && !dec.word && dec.mem)
      |-> (dec.cycles == (narrow_bus_in ? 6'h25 : 6'h22)))
    else $error("signed multiply memory byte timing wrong");

  a_imuli_imm: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ10
    (dec.op == AIDT_OP_SIGNED_MULTIPLY_IMM) |-> (dec.imm_word == !insn_in.opcode[1]))
    else $error("immediate multiply width wrong");

  a_start_ready: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    (ce_in && start) |=> (ce_in -> !ready_out))
    else $error("issue not held after start");

  a_sbb_pair_dec: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ1
    (insn_in.opcode[7:2] == 6'h06)
      |-> (dec.op == AIDT_OP_BORROW_SUBTRACT && dec.form == AIDT_FORM_PAIR))
    else $error("borrow-subtract pair misdecoded");

  a_sbb_imm_dec: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ1
    (insn_in.opcode[7:2] == 6'h20 && insn_in.modrm[5:3] == 3'h3)
      |-> (dec.op == AIDT_OP_BORROW_SUBTRACT && dec.form == AIDT_FORM_IMM_RM))
    else $error("borrow-subtract immediate misdecoded");

  a_sbb_imm_time: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ2
    (dec.op == AIDT_OP_BORROW_SUBTRACT && dec.form == AIDT_FORM_IMM_RM)
      |-> (dec.cycles == (dec.mem ? 6'h10 : 6'h04)))
    else $error("borrow-subtract immediate timing wrong");

  a_sbb_acc_mem: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ2
    (dec.form == AIDT_FORM_IMM_ACC) |-> !dec.mem)
    else $error("accumulator form marked as memory");

  a_padd_time: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ5
    (insn_in.opcode == 8'h27)
      |-> (dec.op == AIDT_OP_PACKED_ADD_CORRECT && dec.cycles == 6'h04))
    else $error("packed add correction misdecoded");

  a_usub_time: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ6
    (insn_in.opcode == 8'h3f)
      |-> (dec.op == AIDT_OP_UNPACKED_SUB_CORRECT && dec.cycles == 6'h07))
    else $error("unpacked subtract correction misdecoded");

  a_psub_time: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ7
    (insn_in.opcode == 8'h2f)
      |-> (dec.op == AIDT_OP_PACKED_SUB_CORRECT && dec.cycles == 6'h04))
    else $error("packed subtract correction misdecoded");

  a_adjust_single: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ4
    (dec.op == AIDT_OP_UNPACKED_ADD_CORRECT) |-> (!dec.mem && dec.form == AIDT_FORM_SINGLE))
    else $error("unpacked add correction form wrong");

  a_mul_reg_byte: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ8
    (insn_in.opcode == 8'hf6 && insn_in.modrm[7:3] == 5'h1c)
      |-> (dec.op == AIDT_OP_UNSIGNED_MULTIPLY && dec.cycles == 6'h1c))
    else $error("unsigned multiply register byte wrong");

  a_mul_reg_word: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ8
    (insn_in.opcode == 8'hf7 && insn_in.modrm[7:3] == 5'h1c)
      |-> (dec.op == AIDT_OP_UNSIGNED_MULTIPLY && dec.cycles == 6'h25))
    else $error("unsigned multiply register word wrong");

  a_mul_mem_byte: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ8
    (dec.op == AIDT_OP_UNSIGNED_MULTIPLY && !dec.word && dec.mem) |-> (dec.cycles == 6'h22))
    else $error("unsigned multiply memory byte timing wrong");

  a_signed_multiply_reg_byte: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ9
    (insn_in.opcode == 8'hf6 && insn_in.modrm[7:3] == 5'h1d)
      |-> (dec.op == AIDT_OP_SIGNED_MULTIPLY && dec.cycles == 6'h1c))
    else $error("signed multiply register byte wrong");

  a_signed_multiply_reg_word: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ9
    (insn_in.opcode == 8'hf7 && insn_in.modrm[7:3] == 5'h1d)
      |-> (dec.op == AIDT_OP_SIGNED_MULTIPLY && dec.cycles == 6'h25))
    else $error("signed multiply register word wrong");

  a_signed_multiply_mem_word: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ9
    (dec.op == AIDT_OP_SIGNED_MULTIPLY && dec.word && dec.mem) |-> (dec.cycles == 6'h2b))
    else $error("signed multiply memory word timing wrong");

  a_imuli_time: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ10
    (insn_in.opcode[7:2] == 6'h1a && insn_in.opcode[0])
      |-> (dec.op == AIDT_OP_SIGNED_MULTIPLY_IMM && dec.cycles == (dec.mem ? 6'h20 : 6'h19)))
    else $error("immediate multiply misdecoded");

  a_imuli_word: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ10
    (dec.op == AIDT_OP_SIGNED_MULTIPLY_IMM) |-> dec.word)
    else $error("immediate multiply not word sized");

  ////////////////////////////////////////////////////////////////////////////
  // issue and stall checks
  a_ce_freeze_out: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    !ce_in |=> ($stable(ready_out) && $stable(busy_out) && $stable(writeback_out)))
    else $error("outputs moved while clock enable low");

  a_ce_freeze_op: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    !ce_in |=> $stable(op_out))
    else $error("operation moved while clock enable low");

  a_unknown_pulse: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    (ce_in && take && !known) |=> (unknown_out && ready_out && !busy_out))
    else $error("unknown opcode not flagged");

  a_unknown_idle: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    unknown_out |-> !busy_out)
    else $error("unknown opcode started execution");

  a_op_held_busy: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    (ce_in && busy_out) |=> $stable(op_out))
    else $error("operation changed during execution");

  a_ready_busy_pair: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    ready_out == !busy_out)
    else $error("ready and busy disagree");

  a_wb_state_match: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    writeback_out == (state == AIDT_WB))
    else $error("writeback pulse outside writeback state");

  a_start_op_latch: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    (ce_in && start) |=> (op_out == $past(dec.op)))
    else $error("operation not latched at start");

  a_count_bound: assert property (@(posedge ref_clk_in) disable iff (!rstn_in) // RQ11
    (state == AIDT_RUN) |-> (count != 6'h00))
    else $error("run state with empty count");

  c_mul_run: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
    start && dec.op == AIDT_OP_UNSIGNED_MULTIPLY);
  c_signed_multiply_narrow: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
    start && dec.op == AIDT_OP_SIGNED_MULTIPLY && narrow_bus_in);
  c_adjust: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
    start && dec.op == AIDT_OP_UNPACKED_SUB_CORRECT);
  c_back_to_back: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
    writeback_out ##1 start);
  c_ce_stall: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
    busy_out && !ce_in);
endmodule

/* File: tb/aidt_fetch_model.sv */
// fetch side model: offers one instruction head at a time
// assumes the core samples valid and ready on the rising clock edge
`timescale 1ns/1ps
module aidt_fetch_model (
  input wire logic ref_clk_in,
  input wire logic ready_in,
  output logic valid_out,
  output aidt_pkg::aidt_insn_s insn_out
);
  import aidt_pkg::*;
  initial begin
    valid_out = 1'b0;
    insn_out = '0;
  end
  ////////////////////////////////////////////////////////////////
  // hold request until taken, then release
  task automatic offer(input aidt_insn_s i);
    @(posedge ref_clk_in);
    valid_out <= 1'b1;
    insn_out <= i;
    do @(posedge ref_clk_in); while (ready_in !== 1'b1);
    valid_out <= 1'b0;
    // released bytes show garbage, not the last head
    insn_out <= ~i;
  endtask
endmodule

/* File: tb/arith_insn_decode_timing_tb.sv */
// testbench for the arithmetic decode and timing core
// assumes fetch model drives the request side; clock enable held on except for the three-cycle stall in test_ce
`timescale 1ns/1ps
module arith_insn_decode_timing_tb;
  import aidt_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic narrow = 1'b0;
  logic ce = 1'b1;
  logic valid, ready, busy, wb, word, mem, immw, unk;
  aidt_insn_s insn;
  aidt_op_e op;
  aidt_form_e form;
  int n_errors = 0;
  int checks_done = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  aidt_core dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce), .valid_in(valid),
    .insn_in(insn), .narrow_bus_in(narrow), .ready_out(ready), .busy_out(busy), .op_out(op),
    .form_out(form), .word_out(word), .mem_out(mem), .imm_word_out(immw),
    .writeback_out(wb), .unknown_out(unk));
  aidt_fetch_model fetch (.ref_clk_in(ref_clk_in), .ready_in(ready), .valid_out(valid),
    .insn_out(insn));
  ////////////////////////////////////////////////////////////////
  // shared helpers
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task run(input logic [7:0] opc, input logic [7:0] modrm, input aidt_op_e exp_op, input int n);
    int k;
    fetch.offer({opc, modrm});
    #1;
    chk("ready_busy", 16'h0, 16'(ready));
    chk("op", 16'(exp_op), 16'(op));
    k = 1;
    while (wb !== 1'b1 && k < 60) begin
      chk("busy_hold", 16'h1, 16'(busy));
      @(posedge ref_clk_in);
      #1;
      k++;
    end
    chk("cycles", 16'(n), 16'(k));
    @(posedge ref_clk_in);
    #1;
    chk("wb_pulse", 16'h0, 16'(wb));
    chk("ready_after", 16'h1, 16'(ready));
    chk("busy_after", 16'h0, 16'(busy));
  endtask
  ////////////////////////////////////////////////////////////////
  // scenarios
  task test_sbb();
    run(8'h18, 8'hc0, AIDT_OP_BORROW_SUBTRACT, 3);
    run(8'h1b, 8'h06, AIDT_OP_BORROW_SUBTRACT, 10);
    chk("pair_form", 16'(AIDT_FORM_PAIR), 16'(form));
    chk("pair_mem_word", 16'h3, 16'({mem, word}));
    run(8'h80, 8'hd8, AIDT_OP_BORROW_SUBTRACT, 4);
    chk("imm_form", 16'(AIDT_FORM_IMM_RM), 16'(form));
    chk("imm_mem_word", 16'h0, 16'({mem, word, immw}));
    run(8'h81, 8'hd8, AIDT_OP_BORROW_SUBTRACT, 4);
    chk("imm_word_sw01", 16'h1, 16'(immw));
    run(8'h83, 8'h1e, AIDT_OP_BORROW_SUBTRACT, 16);
    run(8'h1c, 8'h00, AIDT_OP_BORROW_SUBTRACT, 3);
    run(8'h1d, 8'h00, AIDT_OP_BORROW_SUBTRACT, 4);
    chk("acc_form", 16'(AIDT_FORM_IMM_ACC), 16'(form));
    chk("acc_mem_word", 16'h1, 16'({mem, word}));
  endtask
  task test_neg();
    run(8'hf6, 8'hd8, AIDT_OP_NEGATE_OPERAND, 3);
    run(8'hf7, 8'h18, AIDT_OP_NEGATE_OPERAND, 10);
  endtask
  task test_adjust();
    run(8'h37, 8'h00, AIDT_OP_UNPACKED_ADD_CORRECT, 8);
    run(8'h27, 8'h00, AIDT_OP_PACKED_ADD_CORRECT, 4);
    run(8'h3f, 8'h00, AIDT_OP_UNPACKED_SUB_CORRECT, 7);
    run(8'h2f, 8'h00, AIDT_OP_PACKED_SUB_CORRECT, 4);
  endtask
  task test_mul();
    run(8'hf6, 8'he0, AIDT_OP_UNSIGNED_MULTIPLY, 28);
    run(8'hf7, 8'he0, AIDT_OP_UNSIGNED_MULTIPLY, 37);
    run(8'hf6, 8'h20, AIDT_OP_UNSIGNED_MULTIPLY, 34);
    run(8'hf7, 8'h20, AIDT_OP_UNSIGNED_MULTIPLY, 43);
    chk("mul_mem_word", 16'h3, 16'({mem, word}));
  endtask
  task test_signed_multiply();
    run(8'hf6, 8'he8, AIDT_OP_SIGNED_MULTIPLY, 28);
    run(8'hf7, 8'he8, AIDT_OP_SIGNED_MULTIPLY, 37);
    run(8'hf6, 8'h28, AIDT_OP_SIGNED_MULTIPLY, 34);
    run(8'hf7, 8'h28, AIDT_OP_SIGNED_MULTIPLY, 43);
    @(posedge ref_clk_in);
    narrow <= 1'b1;
    run(8'hf6, 8'h28, AIDT_OP_SIGNED_MULTIPLY, 37);
    @(posedge ref_clk_in);
    narrow <= 1'b0;
  endtask
  task test_signed_multiply_imm();
    run(8'h69, 8'hc0, AIDT_OP_SIGNED_MULTIPLY_IMM, 25);
    chk("imm_word_s0", 16'h1, 16'(immw));
    run(8'h6b, 8'h00, AIDT_OP_SIGNED_MULTIPLY_IMM, 32);
    chk("imm_word_s1", 16'h0, 16'(immw));
  endtask
  task test_hold();
    time t0;
    fetch.offer({8'h37, 8'h00});
    t0 = $time;
    fetch.offer({8'h27, 8'h00});
    chk("issue_gap", 16'h9, 16'(($time - t0) / 10));
    fetch.offer({8'hfe, 8'h08});
    #1;
    chk("unknown", 16'h1, 16'(unk));
    @(posedge ref_clk_in);
    #1;
    chk("ready_unknown", 16'h1, 16'(ready));
  endtask
  task test_ce();
    int k;
    fetch.offer({8'h2f, 8'h00});
    ce <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    ce <= 1'b1;
    #1;
    chk("ce_hold_busy", 16'h1, 16'(busy));
    chk("ce_hold_wb", 16'h0, 16'(wb));
    k = 4;
    while (wb !== 1'b1 && k < 60) begin
      @(posedge ref_clk_in);
      #1;
      k++;
    end
    chk("ce_cycles", 16'(CYC_PSUB) + 16'h3, 16'(k));
    @(posedge ref_clk_in);
    #1;
    chk("ce_ready_after", 16'h1, 16'(ready));
  endtask
  task test_reset_mid();
    fetch.offer({8'hf7, 8'he0});
    repeat (5) @(posedge ref_clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    #1;
    chk("mid_reset_busy", 16'h0, 16'(busy));
    chk("mid_reset_ready", 16'h1, 16'(ready));
    chk("mid_reset_op", 16'(AIDT_OP_NONE), 16'(op));
    run(8'h2f, 8'h00, AIDT_OP_PACKED_SUB_CORRECT, 4);
  endtask
  ////////////////////////////////////////////////////////////////
  // closing and sequence
  task report_and_stop();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    #1;
    chk("reset_ready", 16'h1, 16'(ready));
    chk("reset_op", 16'(AIDT_OP_NONE), 16'(op));
    chk("reset_busy", 16'h0, 16'(busy));
    chk("reset_wb", 16'h0, 16'(wb));
    chk("reset_unknown", 16'h0, 16'(unk));
    chk("reset_form", 16'(AIDT_FORM_SINGLE), 16'(form));
    chk("reset_flags", 16'h0, 16'({word, mem, immw}));
    test_sbb();
    test_neg();
    test_adjust();
    test_mul();
    test_signed_multiply();
    test_signed_multiply_imm();
    test_hold();
    test_ce();
    test_reset_mid();
    report_and_stop();
  end
endmodule
